// file: paged_config_loader.sv
// Behaviour
// - one of eight pages per cycle
// - sample page select when oe rises
// - page number binary, bit 2 msb
// - start and length from option table
// - read entry, then jump to start
// - paging identical in every width mode
// - expand compressed words on the fly
// - 16-bit flash reads, up to 8 out
// - no write: we_n held high always
// - no flash access while powerdown low
// - data changes on config clock fall
//
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
module paged_config_loader #(
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // avalon-mm slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // configuration handshake
    input wire logic i_oe,
    input wire logic [2:0] i_page_select,
    // flash
    input wire logic [15:0] i_flash_data,
    input wire logic i_flash_powerdown_n,
    output paged_config_pkg::flash_bus_t o_flash,
    // target fpga
    output logic o_config_clock,
    output logic [7:0] o_config_data,
    output logic o_config_done
);
    if (FIFO_DEPTH < 2)
    begin : g_bad_param
        $error("FIFO_DEPTH must be at least 2");
    end

    paged_config_pkg::state_t state_reg;
    paged_config_pkg::ctrl_t ctrl_reg;
    logic [2:0] page_reg;
    logic oe_prev_reg;
    logic [20:0] addr_reg;
    logic [paged_config_pkg::WAIT_W-1:0] wait_reg;
    logic [1:0] idx_reg;
    logic [20:0] start_reg;
    logic [5:0] len_hi_reg;
    logic [21:0] words_left_reg;
    logic [21:0] count_reg;
    logic oe_rise;
    logic access_done;
    logic reading;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [15:0] fifo_out_data;
    logic [21:0] opt_len;
    // serializer state
    logic [3:0] div_reg;
    logic pending_reg;
    logic [7:0] sh_reg;
    logic [3:0] bits_reg;
    logic [15:0] word_reg;
    logic have_reg;
    logic half_reg;
    logic [7:0] rep_reg;
    logic [3:0] width;
    logic [7:0] mask;
    logic [7:0] byte_val;
    logic fall_tick;
    logic load_byte;
    logic word_done;
    logic ser_idle;

    assign oe_rise = i_oe && !oe_prev_reg;
    // the flash ignores its pins while powered down, so the wait stalls
    assign access_done = (wait_reg == '0) && i_flash_powerdown_n;
    assign reading = (state_reg == paged_config_pkg::ST_OPT) ||
                     (state_reg == paged_config_pkg::ST_FETCH);
    assign fifo_in_valid = (state_reg == paged_config_pkg::ST_FETCH) &&
                           access_done;
    assign opt_len = {len_hi_reg, i_flash_data};

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            oe_prev_reg <= 1'b0;
        end
        else
        begin
            oe_prev_reg <= i_oe;
        end
    end

    // sequencer: option entry, then page words; oe low aborts
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= paged_config_pkg::ST_IDLE;
            page_reg <= '0;
            addr_reg <= '0;
            wait_reg <= '0;
            idx_reg <= '0;
            start_reg <= '0;
            len_hi_reg <= '0;
            words_left_reg <= '0;
        end
        else if (!i_oe)
        begin
            state_reg <= paged_config_pkg::ST_IDLE;
        end
        else
        begin
            if (i_flash_powerdown_n && wait_reg != '0)
            begin
                wait_reg <= wait_reg - 1'b1;
            end
            case (state_reg)
                paged_config_pkg::ST_IDLE:
                begin
                    if (oe_rise)
                    begin
                        page_reg <= i_page_select;
                        addr_reg <= paged_config_pkg::OPT_BASE +
                            21'({i_page_select, 2'b00});
                        wait_reg <= paged_config_pkg::WAIT_W'(
                            paged_config_pkg::FLASH_WAIT_LOAD);
                        idx_reg <= '0;
                        state_reg <= paged_config_pkg::ST_OPT;
                    end
                end
                paged_config_pkg::ST_OPT:
                begin
                    if (access_done)
                    begin
                        idx_reg <= idx_reg + 1'b1;
                        addr_reg <= addr_reg + 1'b1;
                        wait_reg <= paged_config_pkg::WAIT_W'(
                            paged_config_pkg::FLASH_WAIT_LOAD);
                        case (idx_reg)
                            paged_config_pkg::OPT_START_HI:
                                start_reg[20:16] <= i_flash_data[4:0];
                            paged_config_pkg::OPT_START_LO:
                                start_reg[15:0] <= i_flash_data;
                            paged_config_pkg::OPT_LEN_HI:
                                len_hi_reg <= i_flash_data[5:0];
                            default:
                            begin
                                words_left_reg <= opt_len;
                                addr_reg <= start_reg;
                                state_reg <= (opt_len == '0) ?
                                    paged_config_pkg::ST_DRAIN :
                                    paged_config_pkg::ST_FETCH;
                            end
                        endcase
                    end
                end
                paged_config_pkg::ST_FETCH:
                begin
                    // a full fifo stalls the flash reads
                    if (fifo_in_valid && fifo_in_ready)
                    begin
                        addr_reg <= addr_reg + 1'b1;
                        wait_reg <= paged_config_pkg::WAIT_W'(
                            paged_config_pkg::FLASH_WAIT_LOAD);
                        words_left_reg <= words_left_reg - 1'b1;
                        if (words_left_reg == 22'h000001)
                        begin
                            state_reg <= paged_config_pkg::ST_DRAIN;
                        end
                    end
                end
                paged_config_pkg::ST_DRAIN:
                begin
                    if (!fifo_out_valid && ser_idle)
                    begin
                        state_reg <= paged_config_pkg::ST_DONE;
                    end
                end
                paged_config_pkg::ST_DONE:
                begin
                    state_reg <= paged_config_pkg::ST_DONE;
                end
                default:
                begin
                    state_reg <= paged_config_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // words delivered in this cycle
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            count_reg <= '0;
        end
        else if (state_reg == paged_config_pkg::ST_IDLE && oe_rise)
        begin
            count_reg <= '0;
        end
        else if (fifo_in_valid && fifo_in_ready)
        begin
            count_reg <= count_reg + 1'b1;
        end
    end

    // flash pins, released whenever not reading; never a write
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_flash <= '{addr: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                         drive_en: 1'b0};
        end
        else
        begin
            o_flash.addr <= addr_reg;
            o_flash.ce_n <= !reading;
            o_flash.oe_n <= !reading;
            o_flash.we_n <= 1'b1;
            o_flash.drive_en <= reading;
        end
    end

    word_fifo #(
        .WIDTH(paged_config_pkg::WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_flush(!i_oe),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(i_flash_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(!have_reg),
        .o_out_data(fifo_out_data)
    );

    // serializer datapath
    assign width = 4'h1 << ctrl_reg.width_mode;
    assign mask = 8'((9'h001 << width) - 9'h001);
    // compressed word: high byte is repeat count, low byte the value
    assign byte_val = (ctrl_reg.compress || !half_reg) ?
                      word_reg[7:0] : word_reg[15:8];
    assign word_done = ctrl_reg.compress ?
                       (rep_reg == word_reg[15:8]) : half_reg;
    assign fall_tick = (div_reg == '0) && o_config_clock;
    assign load_byte = fall_tick && bits_reg == '0 && have_reg;
    assign ser_idle = !have_reg && bits_reg == '0 && !pending_reg &&
                      o_config_clock; // last rise already given

    // config clock paced by half_div; rise after fresh data, or once when idle to park high
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            div_reg <= '0;
            o_config_clock <= 1'b0;
            o_config_data <= '0;
            pending_reg <= 1'b0;
            sh_reg <= '0;
            bits_reg <= '0;
            word_reg <= '0;
            have_reg <= 1'b0;
            half_reg <= 1'b0;
            rep_reg <= '0;
        end
        else if (!i_oe)
        begin
            o_config_clock <= 1'b0;
            o_config_data <= '0;
            pending_reg <= 1'b0;
            bits_reg <= '0;
            have_reg <= 1'b0;
            half_reg <= 1'b0;
            rep_reg <= '0;
        end
        else
        begin
            if (!have_reg && fifo_out_valid)
            begin
                word_reg <= fifo_out_data;
                have_reg <= 1'b1;
            end
            if (div_reg != '0)
            begin
                div_reg <= div_reg - 1'b1;
            end
            else if (o_config_clock && (bits_reg != '0 || have_reg))
            begin
                // fall only with data, else a rise would repeat stale bits
                div_reg <= (ctrl_reg.half_div == '0) ? '0 :
                           ctrl_reg.half_div - 1'b1;
                o_config_clock <= 1'b0;
                // new data only on the falling edge
                if (bits_reg != '0)
                begin
                    o_config_data <= sh_reg & mask;
                    sh_reg <= sh_reg >> width;
                    bits_reg <= bits_reg - width;
                    pending_reg <= 1'b1;
                end
                else if (load_byte)
                begin
                    o_config_data <= byte_val & mask;
                    sh_reg <= byte_val >> width;
                    bits_reg <= 4'h8 - width;
                    pending_reg <= 1'b1;
                    half_reg <= !word_done && !ctrl_reg.compress;
                    rep_reg <= word_done ? 8'h00 : rep_reg + 8'h01;
                    have_reg <= !word_done;
                end
            end
            else if (pending_reg)
            begin
                div_reg <= (ctrl_reg.half_div == '0) ? '0 :
                           ctrl_reg.half_div - 1'b1;
                o_config_clock <= 1'b1;
                pending_reg <= 1'b0;
            end
            else if (!have_reg && bits_reg == '0 && !fifo_out_valid)
            begin
                o_config_clock <= 1'b1; // idle high parks next fall
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_config_done <= 1'b0;
        end
        else
        begin
            o_config_done <= state_reg == paged_config_pkg::ST_DONE;
        end
    end

    // avalon slave: one wait cycle, then answer
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= '0;
            ctrl_reg <= paged_config_pkg::CTRL_RESET;
        end
        else if (o_avs_waitrequest && (i_avs_read || i_avs_write))
        begin
            o_avs_waitrequest <= 1'b0;
            case (i_avs_address)
                paged_config_pkg::REG_CTRL:
                    o_avs_readdata <= 32'(ctrl_reg);
                paged_config_pkg::REG_STATUS:
                    o_avs_readdata <= 32'({o_flash.drive_en, page_reg,
                        state_reg == paged_config_pkg::ST_DONE,
                        state_reg != paged_config_pkg::ST_IDLE});
                paged_config_pkg::REG_COUNT:
                    o_avs_readdata <= 32'(count_reg);
                default:
                    o_avs_readdata <= '0;
            endcase
        end
        else
        begin
            o_avs_waitrequest <= 1'b1;
            // write lands on the edge that sees waitrequest low
            if (!o_avs_waitrequest && i_avs_write && i_avs_byteenable[0] &&
                i_avs_address == paged_config_pkg::REG_CTRL)
            begin
                ctrl_reg <= paged_config_pkg::ctrl_t'(
                    i_avs_writedata[paged_config_pkg::CTRL_W-1:0]);
            end
        end
    end

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_start;
        state_reg == paged_config_pkg::ST_IDLE && oe_rise && i_oe;
    endsequence
    sequence s_opt_entry;
        state_reg == paged_config_pkg::ST_OPT &&
        addr_reg == paged_config_pkg::OPT_BASE + 21'({page_reg, 2'b00});
    endsequence

    property p_page_capture;
        s_start |=> page_reg == $past(i_page_select);
    endproperty
    a_page_capture: assert property (p_page_capture)
        else $error("page not captured at oe rise");
    property p_opt_addr;
        s_start |=> s_opt_entry;
    endproperty
    a_opt_addr: assert property (p_opt_addr)
        else $error("option entry address wrong");
    property p_page_hold;
        (state_reg != paged_config_pkg::ST_IDLE &&
         $past(state_reg) != paged_config_pkg::ST_IDLE) |-> $stable(page_reg);
    endproperty
    a_page_hold: assert property (p_page_hold)
        else $error("page changed mid cycle");
    property p_no_write;
        !o_flash.ce_n |-> o_flash.we_n;
    endproperty
    a_no_write: assert property (p_no_write)
        else $error("flash write enabled");
    property p_powerdown;
        !i_flash_powerdown_n |-> !fifo_in_valid ##1 $stable(addr_reg);
    endproperty
    a_powerdown: assert property (p_powerdown)
        else $error("flash read while powered down");
    property p_release;
        state_reg == paged_config_pkg::ST_DONE |->
            !o_flash.drive_en && o_flash.ce_n;
    endproperty
    a_release: assert property (p_release)
        else $error("flash not released when done");
    property p_fall_data;
        (i_oe && $past(i_oe) && $changed(o_config_data)) |->
            $fell(o_config_clock);
    endproperty
    a_fall_data: assert property (p_fall_data)
        else $error("data changed off falling edge");
    property p_count;
        fifo_in_valid && fifo_in_ready |=>
            count_reg == $past(count_reg) + 22'h000001;
    endproperty
    a_count: assert property (p_count)
        else $error("word count not advanced");
    property p_width;
        fall_tick && i_oe && $stable(ctrl_reg) |=>
            (o_config_data & ~mask) == 8'h00;
    endproperty
    a_width: assert property (p_width)
        else $error("unused data lines not low");
endmodule : paged_config_loader

// file: paged_config_pkg.sv
package paged_config_pkg;
    // flash geometry
    localparam int ADDR_W = 21;
    localparam int WORD_W = 16;
    localparam int LEN_W = 22;
    localparam int PAGE_W = 3;
    localparam int NUM_PAGES = 8;
    // option-bit table: four words per page entry
    localparam logic [20:0] OPT_BASE = 21'h000000;
    localparam int OPT_ENTRY_LOG2 = 2;
    localparam logic [1:0] OPT_START_HI = 2'h0;
    localparam logic [1:0] OPT_START_LO = 2'h1;
    localparam logic [1:0] OPT_LEN_HI = 2'h2;
    localparam logic [1:0] OPT_LEN_LO = 2'h3;
    localparam int START_HI_W = 5;
    localparam int LEN_HI_W = 6;
    // flash read timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int FLASH_ACCESS_NS = 90;
    localparam int FLASH_ACCESS_CYC =
        (FLASH_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // one extra cycle because the flash pins are registered
    localparam int FLASH_WAIT_LOAD = FLASH_ACCESS_CYC + 1;
    localparam int WAIT_W = $clog2(FLASH_WAIT_LOAD + 1);
    // register map, byte addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_COUNT = 4'h8;
    localparam int CTRL_W = 7;
    localparam logic [6:0] CTRL_RESET = 7'h08;
    // output width modes: n = 1, 2, 4, 8 data lines
    localparam logic [1:0] MODE_X1 = 2'h0;
    localparam logic [1:0] MODE_X8 = 2'h3;

    typedef struct packed {
        logic [3:0] half_div;
        logic [1:0] width_mode;
        logic compress;
    } ctrl_t;

    typedef struct packed {
        logic [20:0] addr;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic drive_en;
    } flash_bus_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_OPT = 6'h02,
        ST_FETCH = 6'h04,
        ST_DRAIN = 6'h08,
        ST_DONE = 6'h10,
        ST_SPARE = 6'h20
    } state_t;
endpackage : paged_config_pkg

// file: word_fifo.sv
`timescale 1ns/100ps
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_flush,
    // fill side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PTR_W = $clog2(DEPTH);

    // pointer wrap relies on a power-of-two depth
    if (DEPTH < 2 || (1 << PTR_W) != DEPTH)
    begin : g_bad_depth
        $error("word_fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W:0] wr_reg;
    logic [PTR_W:0] rd_reg;
    logic push;
    logic pop;

    // extra pointer bit tells full from empty
    assign o_in_ready = (wr_reg - rd_reg) != (PTR_W+1)'(DEPTH);
    assign o_out_valid = wr_reg != rd_reg;
    assign o_out_data = mem[rd_reg[PTR_W-1:0]];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // storage, no reset needed
    always_ff @(posedge i_sys_clk)
    begin
        if (push)
        begin
            mem[wr_reg[PTR_W-1:0]] <= i_in_data;
        end
    end

    // pointers
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
        end
        else if (i_flush)
        begin
            wr_reg <= '0;
            rd_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule : word_fifo

// file: flash_model.sv
`timescale 1ns/100ps
module flash_model (
    // clock
    input wire logic i_sys_clk,
    // flash pins
    input wire logic [20:0] i_addr,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_powerdown_n,
    output logic [15:0] o_data = 16'h0000
);
    logic [15:0] mem [0:63];
    logic [20:0] addr_q = 21'h000000;
    int age = 0;

    // access restarts on new address; released bus toggles, never holds
    always @(posedge i_sys_clk)
    begin
        addr_q <= i_addr;
        if (i_addr != addr_q || i_ce_n || i_oe_n || !i_powerdown_n)
            age <= 0;
        else
            age <= age + 1;
        if (!i_ce_n && !i_oe_n && i_powerdown_n && age > 1)
            o_data <= mem[i_addr[5:0]];
        else
            o_data <= ~o_data;
    end
endmodule : flash_model

// file: paged_config_loader_tb.sv
`timescale 1ns/100ps
module paged_config_loader_tb;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic rd_en = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    logic wait_req;
    logic oe = 1'b0;
    logic [2:0] page_select = 3'h0;
    logic powerdown_n = 1'b0;
    logic [15:0] flash_data;
    paged_config_pkg::flash_bus_t flash;
    logic config_clock;
    logic [7:0] config_data;
    logic config_done;
    int n_errors = 0;
    int checks = 0;
    int width = 1;
    logic clk_prev = 1'b0;
    logic armed = 1'b0;
    logic [7:0] data_prev = 8'h00;
    logic bits [$];
    logic [7:0] exp_b [$];
    logic [31:0] rd;

    initial
    begin
        forever #2 i_sys_clk = ~i_sys_clk;
    end

    paged_config_loader i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_avs_address(addr), .i_avs_read(rd_en), .i_avs_write(wr_en),
        .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .i_oe(oe),
        .i_page_select(page_select), .i_flash_data(flash_data),
        .i_flash_powerdown_n(powerdown_n), .o_flash(flash),
        .o_config_clock(config_clock), .o_config_data(config_data),
        .o_config_done(config_done));

    flash_model i_flash (.i_sys_clk(i_sys_clk), .i_addr(flash.addr),
        .i_ce_n(flash.ce_n), .i_oe_n(flash.oe_n),
        .i_powerdown_n(powerdown_n), .o_data(flash_data));

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        if (n_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    // one avalon access; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_sys_clk);
        addr <= a;
        wr_en <= wr;
        rd_en <= !wr;
        wdata <= d;
        do
        begin
            @(posedge i_sys_clk);
            n++;
        end while (wait_req !== 1'b0 && n < 50);
        if (wait_req !== 1'b0)
        begin
            n_errors++;
            conclude();
        end
        rd = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask : bus

    function automatic logic [7:0] get_byte(input int i);
        logic [7:0] b;
        for (int j = 0; j < 8; j++)
            b[j] = bits[8*i+j];
        return b;
    endfunction : get_byte

    // watch the flash and target pins; collect bits on clock rises
    always @(negedge i_sys_clk)
    begin
        if (!i_rst)
        begin
            chk("we_n", flash.we_n, 1'b1);
            if (oe && config_data !== data_prev)
                chk("data edge", {clk_prev, config_clock}, 2'b10);
            if (oe && armed && !clk_prev && config_clock)
                for (int i = 0; i < width; i++)
                    bits.push_back(config_data[i]);
            if (clk_prev && !config_clock)
                armed = 1'b1;
        end
        clk_prev = config_clock;
        data_prev = config_data;
    end

    // one full configuration cycle of page p
    task automatic run(input logic [2:0] p, input logic [6:0] ctrl,
        input int len, input bit gap);
        int n;
        bus(1'b1, paged_config_pkg::REG_CTRL, {25'h0, ctrl});
        bus(1'b0, paged_config_pkg::REG_CTRL, 32'h0);
        chk("ctrl", rd, {25'h0, ctrl});
        width = 1 << ctrl[2:1];
        bits.delete();
        armed = 1'b0;
        page_select <= p;
        @(posedge i_sys_clk);
        oe <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        page_select <= ~p;
        if (gap)
        begin
            repeat (10) @(posedge i_sys_clk);
            powerdown_n <= 1'b0;
            repeat (60) @(posedge i_sys_clk);
            powerdown_n <= 1'b1;
        end
        n = 0;
        do
        begin
            @(negedge i_sys_clk);
            n++;
        end while (config_done !== 1'b1 && n < 20000);
        chk("done", config_done, 1'b1);
        if (config_done !== 1'b1)
        begin
            conclude();
        end
        chk("drive_en", flash.drive_en, 1'b0);
        chk("bits", bits.size(), exp_b.size() * 8);
        for (int i = 0; i < exp_b.size(); i++)
            chk("byte", get_byte(i), exp_b[i]);
        bus(1'b0, paged_config_pkg::REG_STATUS, 32'h0);
        chk("page", rd[4:2], p);
        bus(1'b0, paged_config_pkg::REG_COUNT, 32'h0);
        chk("count", rd, len);
        oe <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk("done low", config_done, 1'b0);
    endtask : run

    initial
    begin
        for (int i = 0; i < 64; i++)
            i_flash.mem[i] = 16'h0000;
        i_flash.mem[21] = 16'h0028;
        i_flash.mem[23] = 16'h0003;
        i_flash.mem[5] = 16'h0030;
        i_flash.mem[7] = 16'h0002;
        i_flash.mem[40] = 16'hA51C;
        i_flash.mem[41] = 16'h3C96;
        i_flash.mem[42] = 16'h0F81;
        i_flash.mem[48] = 16'h02C3;
        i_flash.mem[49] = 16'h005A;
        repeat (4) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        powerdown_n <= 1'b1;
        @(negedge i_sys_clk);
        chk("rst wait", wait_req, 1'b1);
        chk("rst ce_n", flash.ce_n, 1'b1);
        chk("rst drive", flash.drive_en, 1'b0);
        bus(1'b0, paged_config_pkg::REG_CTRL, 32'h0);
        chk("ctrl rst", rd, 32'h00000008);
        bus(1'b1, paged_config_pkg::REG_STATUS, 32'hFFFFFFFF);
        bus(1'b0, paged_config_pkg::REG_STATUS, 32'h0);
        chk("status", rd, 32'h00000000);
        bus(1'b0, 4'hC, 32'h0);
        chk("unmapped", rd, 32'h00000000);
        exp_b = '{8'h1C, 8'hA5, 8'h96, 8'h3C, 8'h81, 8'h0F};
        for (int m = 0; m < 4; m++)
            run(3'h5, {4'h1, 2'(m), 1'b0}, 3, m == 0);
        exp_b = '{8'hC3, 8'hC3, 8'hC3, 8'h5A};
        run(3'h1, 7'h0F, 2, 1'b0);
        @(posedge i_sys_clk);
        page_select <= 3'h1;
        oe <= 1'b1;
        // long enough that a first byte is already on the data lines
        repeat (140) @(posedge i_sys_clk);
        oe <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        chk("abort drive", flash.drive_en, 1'b0);
        chk("abort data", config_data, 8'h00);
        exp_b = {};
        run(3'h0, 7'h08, 0, 1'b0);
        conclude();
    end

    initial
    begin
        repeat (100000) @(posedge i_sys_clk);
        n_errors++;
        conclude();
    end
endmodule : paged_config_loader_tb
